//--- hdl/timer_pkg.sv
// Shared constants and types for the capture timer
package timer_pkg;
	// Register byte addresses
	localparam logic [31:0] ADDR_LOAD = 32'hFFFF0320;
	localparam logic [31:0] ADDR_VALUE = 32'hFFFF0324;
	localparam logic [31:0] ADDR_CTRL = 32'hFFFF0328;
	localparam logic [31:0] ADDR_CLEAR = 32'hFFFF032C;
	localparam logic [31:0] ADDR_CAPT = 32'hFFFF0330;
	// Reset values and count limits
	localparam logic [31:0] LOAD_RST = 32'h00000000;
	localparam logic [31:0] COUNT_RST = 32'h0FFFFFFF;
	localparam logic [31:0] COUNT_MAX = 32'hFFFFFFFF;
	localparam logic [31:0] COUNT_ZERO = 32'h00000000;
	// Control field positions
	localparam int POST_HI = 31;
	localparam int POST_LO = 24;
	localparam int POST_EN = 23;
	localparam int ISRC = 18;
	localparam int CAP_EN = 17;
	localparam int EVT_HI = 16;
	localparam int EVT_LO = 12;
	localparam int CSEL_HI = 11;
	localparam int CSEL_LO = 9;
	localparam int UP = 8;
	localparam int RUN = 7;
	localparam int PERIODIC = 6;
	localparam int FMT_HI = 5;
	localparam int FMT_LO = 4;
	localparam int PRE_HI = 3;
	localparam int PRE_LO = 0;
	// Clock source codes
	localparam logic [2:0] CS_CORE = 3'h0;
	localparam logic [2:0] CS_LPOSC = 3'h1;
	localparam logic [2:0] CS_GPIO_A = 3'h2;
	localparam logic [2:0] CS_GPIO_B = 3'h3;
	// Prescaler codes and terminal counts
	localparam logic [3:0] PRE_DIV16 = 4'h4;
	localparam logic [3:0] PRE_DIV256 = 4'h8;
	localparam logic [3:0] PRE_DIV32768 = 4'hF;
	localparam logic [14:0] LIM_DIV1 = 15'h0000;
	localparam logic [14:0] LIM_DIV16 = 15'h000F;
	localparam logic [14:0] LIM_DIV256 = 15'h00FF;
	localparam logic [14:0] LIM_DIV32768 = 15'h7FFF;
	// Count formats
	localparam logic [1:0] FMT_BIN = 2'h0;
	localparam logic [1:0] FMT_HMS255 = 2'h3;
	// Time field limits
	localparam logic [7:0] HUND_MAX = 8'h63;
	localparam logic [7:0] MINSEC_MAX = 8'h3B;
	localparam logic [7:0] HR23_MAX = 8'h17;
	localparam logic [7:0] HR255_MAX = 8'hFF;
	// Time-format count layout
	typedef struct packed {
		logic [7:0] hr;
		logic [7:0] mn;
		logic [7:0] sc;
		logic [7:0] hu;
	} hms_t;
endpackage

//--- hdl/capture_timer.sv
// Up/down timer with prescaler, time format, post-scaler and event capture
//
// Added by the designer: strobed register access.
module capture_timer (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic [31:0] addr,
	input wire logic [31:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [31:0] rd_data,
	input wire logic lp_osc_in,
	input wire logic gpio_a_in,
	input wire logic gpio_b_in,
	input wire logic [31:0] irq_sources,
	input wire logic low_power,
	output logic timer_irq
);
	// Whole block state
	typedef struct packed {
		logic [31:0] load;
		logic [31:0] count;
		logic [31:0] capture;
		logic [7:0] post_val;
		logic [7:0] post_cnt;
		logic post_en;
		logic post_flag;
		logic isrc;
		logic cap_en;
		logic [4:0] evt_sel;
		logic [2:0] csel;
		logic up;
		logic run;
		logic periodic;
		logic [1:0] fmt;
		logic [3:0] pre;
		logic [14:0] pre_cnt;
		logic [2:0] sync0;
		logic [2:0] sync1;
		logic [2:0] sync2;
		logic [2:0] lvl;
		logic evt_prev;
		logic irq;
		logic [31:0] rd_data;
	} state_t;

	state_t st_reg; // Registered state
	state_t st_next; // Next state
	logic step; // Counter advances this cycle
	logic at_end; // Count sits at its terminal value
	logic timeout; // Step taken at terminal value
	logic match; // Post-scaler reached its target
	logic evt; // Interrupt event
	logic clr_wr; // Write to the clear register
	logic ctl_wr; // Write to the control register
	logic cap_hit; // Capture event taken
	timer_pkg::hms_t cur_hms; // Count seen as time fields, for the checks

	// Prescaler terminal count per code; unlisted codes divide by one
	function automatic logic [14:0] pre_limit(input logic [3:0] code);
		case (code)
			timer_pkg::PRE_DIV16: pre_limit = timer_pkg::LIM_DIV16;
			timer_pkg::PRE_DIV256: pre_limit = timer_pkg::LIM_DIV256;
			timer_pkg::PRE_DIV32768: pre_limit = timer_pkg::LIM_DIV32768;
			default: pre_limit = timer_pkg::LIM_DIV1;
		endcase
	endfunction

	// Full-scale value of the time format
	function automatic logic [31:0] hms_full(input logic [7:0] hmax);
		timer_pkg::hms_t r;
		r.hr = hmax;
		r.mn = timer_pkg::MINSEC_MAX;
		r.sc = timer_pkg::MINSEC_MAX;
		r.hu = timer_pkg::HUND_MAX;
		hms_full = r;
	endfunction

	// One step of the time format count, either direction
	function automatic logic [31:0] hms_step(input logic [31:0] v, input logic up,
		input logic [7:0] hmax);
		timer_pkg::hms_t t;
		timer_pkg::hms_t r;
		t = v;
		r = t;
		if (up) begin
			// Ripple carry through the fields
			if (t.hu != timer_pkg::HUND_MAX) begin
				r.hu = t.hu + 8'h01;
			end else begin
				r.hu = 8'h00;
				if (t.sc != timer_pkg::MINSEC_MAX) begin
					r.sc = t.sc + 8'h01;
				end else begin
					r.sc = 8'h00;
					if (t.mn != timer_pkg::MINSEC_MAX) begin
						r.mn = t.mn + 8'h01;
					end else begin
						r.mn = 8'h00;
						r.hr = (t.hr == hmax) ? 8'h00 : t.hr + 8'h01;
					end
				end
			end
		end else begin
			// Ripple borrow through the fields
			if (t.hu != 8'h00) begin
				r.hu = t.hu - 8'h01;
			end else begin
				r.hu = timer_pkg::HUND_MAX;
				if (t.sc != 8'h00) begin
					r.sc = t.sc - 8'h01;
				end else begin
					r.sc = timer_pkg::MINSEC_MAX;
					if (t.mn != 8'h00) begin
						r.mn = t.mn - 8'h01;
					end else begin
						r.mn = timer_pkg::MINSEC_MAX;
						r.hr = (t.hr == 8'h00) ? hmax : t.hr - 8'h01;
					end
				end
			end
		end
		hms_step = r;
	endfunction

	// Next-state logic
	always_comb begin
		logic [2:0] lvl_n;
		logic [2:0] rise;
		logic src_tick;
		logic bin;
		logic [7:0] hmax;
		logic [31:0] full;
		logic [7:0] target;
		logic evt_lvl;
		lvl_n = 3'h0;
		rise = 3'h0;
		src_tick = 1'b0;
		bin = 1'b0;
		hmax = 8'h00;
		full = 32'h00000000;
		target = 8'h00;
		evt_lvl = 1'b0;
		match = 1'b0;
		st_next = st_reg;
		clr_wr = wr_en && (addr == timer_pkg::ADDR_CLEAR);
		ctl_wr = wr_en && (addr == timer_pkg::ADDR_CTRL);
		// Three-stage sync; a level change needs stages two and three to agree
		st_next.sync0 = {gpio_b_in, gpio_a_in, lp_osc_in};
		st_next.sync1 = st_reg.sync0;
		st_next.sync2 = st_reg.sync1;
		lvl_n = (st_reg.sync1 & st_reg.sync2) | (st_reg.lvl & (st_reg.sync1 ^ st_reg.sync2));
		st_next.lvl = lvl_n;
		rise = lvl_n & ~st_reg.lvl;
		// Source selection; core clock halts in low power
		case (st_reg.csel)
			timer_pkg::CS_CORE: src_tick = !low_power;
			timer_pkg::CS_LPOSC: src_tick = rise[0];
			timer_pkg::CS_GPIO_A: src_tick = rise[1];
			timer_pkg::CS_GPIO_B: src_tick = rise[2];
			default: src_tick = 1'b0;
		endcase
		// Prescaler
		step = 1'b0;
		if (st_reg.run && src_tick) begin
			if (st_reg.pre_cnt == pre_limit(st_reg.pre)) begin
				st_next.pre_cnt = 15'h0000;
				step = 1'b1;
			end else begin
				st_next.pre_cnt = st_reg.pre_cnt + 15'h0001;
			end
		end
		// Terminal values of the chosen format; reserved code counts binary
		bin = (st_reg.fmt == timer_pkg::FMT_BIN) || !st_reg.fmt[1];
		hmax = (st_reg.fmt == timer_pkg::FMT_HMS255) ? timer_pkg::HR255_MAX :
			timer_pkg::HR23_MAX;
		full = bin ? timer_pkg::COUNT_MAX : hms_full(hmax);
		at_end = st_reg.up ? (st_reg.count == full) : (st_reg.count == timer_pkg::COUNT_ZERO);
		timeout = step && at_end;
		// Counter update
		if (step) begin
			if (at_end) begin
				if (st_reg.periodic) begin
					st_next.count = st_reg.load;
				end else begin
					st_next.count = st_reg.up ? timer_pkg::COUNT_ZERO : full;
				end
			end else if (bin) begin
				st_next.count = st_reg.up ? st_reg.count + 32'h00000001 :
					st_reg.count - 32'h00000001;
			end else begin
				st_next.count = hms_step(st_reg.count, st_reg.up, hmax);
			end
		end
		// Post-scaler counts timeouts; zero target acts as one
		target = (st_reg.post_val == 8'h00) ? 8'h01 : st_reg.post_val;
		if (timeout && st_reg.post_en) begin
			if (st_reg.post_cnt + 8'h01 == target) begin
				match = 1'b1;
				st_next.post_cnt = 8'h00;
			end else begin
				st_next.post_cnt = st_reg.post_cnt + 8'h01;
			end
		end
		evt = st_reg.isrc ? match : timeout;
		// Clear write reloads and clears; a same-cycle event wins
		if (clr_wr) begin
			st_next.count = st_reg.load;
			st_next.irq = 1'b0;
			st_next.post_flag = 1'b0;
		end
		if (evt) begin
			st_next.irq = 1'b1;
		end
		if (match) begin
			st_next.post_flag = 1'b1;
		end
		// Capture on the rising edge of the selected source
		evt_lvl = irq_sources[st_reg.evt_sel];
		st_next.evt_prev = evt_lvl;
		cap_hit = st_reg.cap_en && evt_lvl && !st_reg.evt_prev;
		if (cap_hit) begin
			st_next.capture = st_reg.count;
		end
		// Register writes; value and capture ignore writes
		if (wr_en && (addr == timer_pkg::ADDR_LOAD)) begin
			st_next.load = wr_data;
		end
		if (ctl_wr) begin
			// Reserved and flag bits are not stored
			st_next.post_val = wr_data[timer_pkg::POST_HI:timer_pkg::POST_LO];
			st_next.post_cnt = 8'h00;
			st_next.post_en = wr_data[timer_pkg::POST_EN];
			st_next.isrc = wr_data[timer_pkg::ISRC];
			st_next.cap_en = wr_data[timer_pkg::CAP_EN];
			st_next.evt_sel = wr_data[timer_pkg::EVT_HI:timer_pkg::EVT_LO];
			st_next.csel = wr_data[timer_pkg::CSEL_HI:timer_pkg::CSEL_LO];
			st_next.up = wr_data[timer_pkg::UP];
			st_next.run = wr_data[timer_pkg::RUN];
			st_next.periodic = wr_data[timer_pkg::PERIODIC];
			st_next.fmt = wr_data[timer_pkg::FMT_HI:timer_pkg::FMT_LO];
			st_next.pre = wr_data[timer_pkg::PRE_HI:timer_pkg::PRE_LO];
			st_next.pre_cnt = 15'h0000;
		end
		// Read data valid only in the cycle after the strobe
		st_next.rd_data = 32'h00000000;
		if (rd_en) begin
			case (addr)
				timer_pkg::ADDR_LOAD: st_next.rd_data = st_reg.load;
				timer_pkg::ADDR_VALUE: st_next.rd_data = st_reg.count;
				timer_pkg::ADDR_CAPT: st_next.rd_data = st_reg.capture;
				timer_pkg::ADDR_CTRL: st_next.rd_data = {st_reg.post_cnt, st_reg.post_en,
					3'h0, st_reg.post_flag, st_reg.isrc, st_reg.cap_en, st_reg.evt_sel,
					st_reg.csel, st_reg.up, st_reg.run, st_reg.periodic, st_reg.fmt,
					st_reg.pre};
				default: st_next.rd_data = 32'h00000000;
			endcase
		end
	end

	// State register with synchronous reset
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			st_reg <= '0;
			st_reg.load <= timer_pkg::LOAD_RST;
			st_reg.count <= timer_pkg::COUNT_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs straight from flops
	assign rd_data = st_reg.rd_data;
	assign timer_irq = st_reg.irq;
	// Field view of the live count for the time-format checks
	assign cur_hms = st_reg.count;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	a_clear_reload: assert property (clr_wr |=> st_reg.count == $past(st_reg.load))
		else $error("clear write did not reload count");
	a_clear_irq: assert property (clr_wr && !evt |=> !timer_irq)
		else $error("clear write left interrupt pending");
	a_event_irq: assert property (evt |=> timer_irq [*2] or (timer_irq ##1 !timer_irq))
		else $error("event did not raise interrupt");
	a_stop_hold: assert property (!st_reg.run && !clr_wr |=> $stable(st_reg.count))
		else $error("stopped timer changed count");
	a_down_step: assert property (step && !st_reg.up && !at_end && st_reg.fmt == timer_pkg::FMT_BIN &&
		!clr_wr |=> st_reg.count == $past(st_reg.count) - 32'h00000001)
		else $error("down count did not decrement");
	a_up_step: assert property (step && st_reg.up && !at_end && st_reg.fmt == timer_pkg::FMT_BIN &&
		!clr_wr |=> st_reg.count == $past(st_reg.count) + 32'h00000001)
		else $error("up count did not increment");
	a_core_halt: assert property (st_reg.csel == timer_pkg::CS_CORE && low_power |-> !step)
		else $error("core clock source counted in low power");
	a_free_wrap: assert property (timeout && !st_reg.periodic && st_reg.up && !clr_wr
		|=> st_reg.count == timer_pkg::COUNT_ZERO)
		else $error("free-running up count did not restart at zero");
	a_periodic_load: assert property (timeout && st_reg.periodic && !clr_wr
		|=> st_reg.count == $past(st_reg.load))
		else $error("periodic count did not reload");
	a_capture_copy: assert property (cap_hit |=> st_reg.capture == $past(st_reg.count))
		else $error("capture did not copy count");
	a_post_match: assert property (match && !clr_wr |=> st_reg.post_flag &&
		st_reg.post_cnt == 8'h00)
		else $error("post-scaler match not flagged");
	a_hund_wrap: assert property (step && st_reg.up && st_reg.fmt[1] && !at_end && !clr_wr &&
		cur_hms.hu == timer_pkg::HUND_MAX
		|=> cur_hms.hu == 8'h00)
		else $error("hundredths did not wrap");
	a_read_load: assert property (rd_en && addr == timer_pkg::ADDR_LOAD
		|=> rd_data == $past(st_reg.load))
		else $error("load read back wrong");
	a_value_read: assert property (rd_en && addr == timer_pkg::ADDR_VALUE
		|=> rd_data == $past(st_reg.count))
		else $error("value read back wrong");
	a_ctl_read: assert property (rd_en && addr == timer_pkg::ADDR_CTRL
		|=> rd_data[timer_pkg::POST_HI:timer_pkg::POST_LO] == $past(st_reg.post_cnt))
		else $error("post-scaler count not read back");

	c_capture: cover property (cap_hit);
	c_post_match: cover property (match ##[1:20] clr_wr);
	c_periodic: cover property (timeout && st_reg.periodic);
	c_clear_vs_event: cover property (clr_wr && evt);
	c_time_step: cover property (step && st_reg.fmt[1]);
endmodule

//--- sim/capture_timer_tb.sv
// Self-checking bench for the capture timer, driven through its register port
module capture_timer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk;
	logic srst;
	logic [31:0] addr;
	logic [31:0] wr_data;
	logic wr_en;
	logic rd_en;
	logic [31:0] rd_data;
	logic [2:0] pin_v; // Pin levels: 0 oscillator, 1 GPIO A, 2 GPIO B
	logic [31:0] irq_sources;
	logic low_power;
	logic timer_irq;
	logic rd_pend; // A read answer is due at this edge
	logic [31:0] exp_q [$]; // Expected read data, oldest first
	int err_total;
	int total_checks;
	logic [31:0] v;
	logic [31:0] w;
	int e;
	// Time-format cases: control word, start count, count after one tick
	logic [31:0] tf_c [7] = '{32'h5A0, 32'h5A0, 32'h5A0, 32'h4A0, 32'h4B0, 32'h5B0, 32'h490};
	logic [31:0] tf_s [7] = '{32'h63, 32'h3B3B63, 32'h173B3B63, 32'h0, 32'h0, 32'h173B3B63, 32'h0};
	logic [31:0] tf_e [7] = '{32'h100, 32'h1000000, 32'h0, 32'h173B3B63, 32'hFF3B3B63,
		32'h18000000, 32'hFFFFFFFF};

	capture_timer capture_timer_i (
		.sys_clk(sys_clk),
		.srst(srst),
		.addr(addr),
		.wr_data(wr_data),
		.wr_en(wr_en),
		.rd_en(rd_en),
		.rd_data(rd_data),
		.lp_osc_in(pin_v[0]),
		.gpio_a_in(pin_v[1]),
		.gpio_b_in(pin_v[2]),
		.irq_sources(irq_sources),
		.low_power(low_power),
		.timer_irq(timer_irq)
	);

	// Free-running 100 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// Compare one read answer
	task automatic chk_rd(input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (exp !== got) begin
			err_total++;
			$display("unexpected rd_data: expected %h, seen %h", exp, got);
		end
	endtask

	// Compare the interrupt line at the next edge
	task automatic chk_irq(input logic exp);
		@(posedge sys_clk);
		total_checks++;
		if (timer_irq !== exp) begin
			err_total++;
			$display("unexpected timer_irq: expected %b, seen %b", exp, timer_irq);
		end
	endtask

	// Monitor: takes the oldest note whenever read data is due
	always @(posedge sys_clk) begin
		if (rd_pend === 1'b1) begin
			chk_rd(exp_q.pop_front(), rd_data);
		end
		rd_pend <= rd_en;
	end

	// One-cycle write strobe, then one idle cycle
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge sys_clk);
		wr_en <= 1'b0;
		@(posedge sys_clk);
	endtask

	// One-cycle read strobe; the expectation goes to the queue
	task automatic rd(input logic [31:0] a, input logic [31:0] exp);
		addr <= a;
		rd_en <= 1'b1;
		exp_q.push_back(exp);
		@(posedge sys_clk);
		rd_en <= 1'b0;
		@(posedge sys_clk);
	endtask

	// Load a value and copy it into the counter
	task automatic set_count(input logic [31:0] d);
		wr(timer_pkg::ADDR_LOAD, d);
		wr(timer_pkg::ADDR_CLEAR, $urandom);
	endtask

	// Rising edges on one pin, spaced for the synchroniser
	task automatic pulse(input int which, input int n);
		for (int i = 0; i < n; i++) begin
			pin_v[which] <= 1'b1;
			repeat (3) @(posedge sys_clk);
			pin_v[which] <= 1'b0;
			repeat (3) @(posedge sys_clk);
		end
		repeat (5) @(posedge sys_clk);
	endtask

	// Report counts and the verdict, then stop
	task automatic finish_test;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Watchdog well beyond the roughly 35000 cycles the tests need
	initial begin
		repeat (60000) @(posedge sys_clk);
		err_total++;
		finish_test();
	end

	// Main sequence
	initial begin
		srst = 1'b1;
		addr = 32'h0;
		wr_data = 32'h0;
		wr_en = 1'b0;
		rd_en = 1'b0;
		pin_v = 3'h0;
		irq_sources = 32'h0;
		low_power = 1'b0;
		rd_pend = 1'b0;
		err_total = 0;
		total_checks = 0;
		void'($urandom(32'h99CF58F6));
		repeat (8) @(posedge sys_clk);
		srst <= 1'b0;
		// Reset values, unmapped and write-only places
		rd(timer_pkg::ADDR_LOAD, timer_pkg::LOAD_RST);
		rd(timer_pkg::ADDR_VALUE, timer_pkg::COUNT_RST);
		rd(timer_pkg::ADDR_CTRL, 32'h0);
		rd(timer_pkg::ADDR_CAPT, 32'h0);
		rd(timer_pkg::ADDR_CLEAR, 32'h0);
		rd(32'hFFFF0334, 32'h0);
		chk_irq(1'b0);
		// Read-only places ignore writes; clear copies the load value
		v = $urandom;
		wr(timer_pkg::ADDR_LOAD, v);
		wr(timer_pkg::ADDR_VALUE, ~v);
		wr(timer_pkg::ADDR_CAPT, v);
		rd(timer_pkg::ADDR_LOAD, v);
		rd(timer_pkg::ADDR_VALUE, timer_pkg::COUNT_RST);
		rd(timer_pkg::ADDR_CAPT, 32'h0);
		wr(timer_pkg::ADDR_CLEAR, $urandom);
		rd(timer_pkg::ADDR_VALUE, v);
		// Stopped timer ignores its source
		wr(timer_pkg::ADDR_CTRL, 32'h400);
		pulse(1, 2);
		rd(timer_pkg::ADDR_VALUE, v);
		// Sources and direction, all in low power
		low_power <= 1'b1;
		wr(timer_pkg::ADDR_CTRL, 32'h480);
		pulse(1, 5);
		pulse(2, 3);
		pulse(0, 3);
		rd(timer_pkg::ADDR_VALUE, v - 32'h5);
		wr(timer_pkg::ADDR_CTRL, 32'h580);
		pulse(1, 2);
		rd(timer_pkg::ADDR_VALUE, v - 32'h3);
		wr(timer_pkg::ADDR_CTRL, 32'h780);
		pulse(2, 4);
		pulse(1, 2);
		rd(timer_pkg::ADDR_VALUE, v + 32'h1);
		wr(timer_pkg::ADDR_CTRL, 32'h280);
		pulse(0, 1);
		rd(timer_pkg::ADDR_VALUE, v);
		// Core clock halts in low power
		wr(timer_pkg::ADDR_CTRL, 32'h80);
		repeat (30) @(posedge sys_clk);
		rd(timer_pkg::ADDR_VALUE, v);
		// Prescalers by 16 and 256 on a pin, one step per full group
		for (int i = 0; i < 2; i++) begin
			set_count(32'h64);
			wr(timer_pkg::ADDR_CTRL, 32'h480 | (i ? timer_pkg::PRE_DIV256 : timer_pkg::PRE_DIV16));
			pulse(1, i ? 255 : 15);
			rd(timer_pkg::ADDR_VALUE, 32'h64);
			pulse(1, 1);
			rd(timer_pkg::ADDR_VALUE, 32'h63);
		end
		// Prescaler by 32768 on the core clock
		low_power <= 1'b0;
		set_count(32'h5);
		wr(timer_pkg::ADDR_CTRL, 32'h80 | timer_pkg::PRE_DIV32768);
		repeat (32790) @(posedge sys_clk);
		wr(timer_pkg::ADDR_CTRL, 32'h0);
		rd(timer_pkg::ADDR_VALUE, 32'h4);
		// Free-running wrap both ways, timeout interrupt and its clear
		set_count(timer_pkg::COUNT_ZERO);
		wr(timer_pkg::ADDR_CTRL, 32'h480);
		chk_irq(1'b0);
		pulse(1, 1);
		rd(timer_pkg::ADDR_VALUE, timer_pkg::COUNT_MAX);
		chk_irq(1'b1);
		wr(timer_pkg::ADDR_CLEAR, $urandom);
		chk_irq(1'b0);
		set_count(timer_pkg::COUNT_MAX);
		wr(timer_pkg::ADDR_CTRL, 32'h580);
		pulse(1, 1);
		rd(timer_pkg::ADDR_VALUE, timer_pkg::COUNT_ZERO);
		chk_irq(1'b1);
		// Periodic reload from the load register
		set_count(timer_pkg::COUNT_ZERO);
		w = $urandom;
		wr(timer_pkg::ADDR_LOAD, w);
		wr(timer_pkg::ADDR_CTRL, 32'h4C0);
		pulse(1, 1);
		rd(timer_pkg::ADDR_VALUE, w);
		// Time formats, field wraps and hour limits
		for (int i = 0; i < 7; i++) begin
			set_count(tf_s[i]);
			wr(timer_pkg::ADDR_CTRL, tf_c[i]);
			pulse(1, 1);
			rd(timer_pkg::ADDR_VALUE, tf_e[i]);
		end
		// Post-scaler of three timeouts, interrupt from the match
		set_count(timer_pkg::COUNT_ZERO);
		wr(timer_pkg::ADDR_CTRL, 32'h038404C0);
		pulse(1, 2);
		chk_irq(1'b0);
		rd(timer_pkg::ADDR_CTRL, 32'h028404C0);
		pulse(1, 1);
		chk_irq(1'b1);
		rd(timer_pkg::ADDR_CTRL, 32'h008C04C0);
		wr(timer_pkg::ADDR_CLEAR, $urandom);
		chk_irq(1'b0);
		// Written zero counts as one timeout
		wr(timer_pkg::ADDR_CTRL, 32'h008404C0);
		pulse(1, 1);
		chk_irq(1'b1);
		// Capture on the selected source only, counting goes on
		e = $urandom_range(31, 0);
		v = $urandom;
		set_count(v);
		wr(timer_pkg::ADDR_CTRL, 32'h20480 | (e << 12));
		irq_sources <= 32'h1 << ((e + 1) % 32);
		@(posedge sys_clk);
		rd(timer_pkg::ADDR_CAPT, 32'h0);
		irq_sources <= (32'h1 << ((e + 1) % 32)) | (32'h1 << e);
		@(posedge sys_clk);
		rd(timer_pkg::ADDR_CAPT, v);
		pulse(1, 1);
		rd(timer_pkg::ADDR_VALUE, v - 32'h1);
		rd(timer_pkg::ADDR_CAPT, v);
		irq_sources <= 32'h0;
		repeat (3) @(posedge sys_clk);
		finish_test();
	end
endmodule
